// ---- mrsc_pkg.sv ----
package mrsc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SPD0 = 8'h04;
  localparam logic [7:0] ADDR_SPD1 = 8'h08;
  localparam logic [7:0] ADDR_SPD2 = 8'h0c;
  localparam logic [7:0] ADDR_SPD3 = 8'h10;
  localparam logic [7:0] ADDR_PANEL = 8'h14;
  localparam logic [7:0] ADDR_CMD = 8'h18;
  localparam logic [7:0] ADDR_STAT = 8'h1c;
  localparam logic [7:0] ADDR_SPEED = 8'h20;

  // CTRL fields
  localparam int CTRL_EXT_EN = 0;
  localparam int CTRL_RANGE10 = 1;
  localparam int CTRL_COAST = 2;
  localparam int CTRL_DECEL_OFF = 3;
  localparam int CTRL_HZ60 = 4;
  localparam int CTRL_SOURCE = 5;
  // CMD fields (write-one pulses)
  localparam int CMD_PANEL_WR = 0;
  localparam int CMD_TEST_START = 1;
  localparam int CMD_TEST_STOP = 2;
  localparam int CMD_BRAKE_REL = 3;
  localparam int CMD_BRAKE_HOLD = 4;
  localparam int CMD_ALM_RESET = 5;

  // ----------------------------------------------------------------------
  // Speed limits in r/min
  // ----------------------------------------------------------------------
  localparam logic [10:0] SPD_MIN = 11'd300;
  localparam logic [10:0] SPD_MIN_NODEC = 11'd90;
  localparam logic [10:0] SPD_MAX_50 = 11'd1400;
  localparam logic [10:0] SPD_MAX_60 = 11'd1600;
  localparam logic [10:0] SPD_RUN_50 = 11'd1420;
  localparam logic [10:0] SPD_TEST = 11'd300;
  localparam logic [10:0] SPD_RESET = 11'd300;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int DEB_MS = 10;
  localparam int DEB_CYC = DEB_MS * 1000 * CLK_MHZ;
  localparam int DECEL_STEP_CYC = 250;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    MRSC_IDLE = 5'b00001,
    MRSC_FWD = 5'b00010,
    MRSC_REV = 5'b00100,
    MRSC_DECEL = 5'b01000,
    MRSC_TEST = 5'b10000
  } mrsc_state_t;

  typedef struct packed {
    logic forward_run_in;
    logic reverse_run_in;
    logic sel_lo;
    logic sel_hi;
    logic alm_rst;
    logic free;
  } mrsc_in_t;

  typedef struct packed {
    logic run;
    logic dir_rev;
    logic coast;
    logic brake_rel;
    logic [10:0] speed;
  } mrsc_drive_t;

endpackage

// ---- mrsc_motor_run_speed_control.sv ----
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
module mrsc_motor_run_speed_control #(
  parameter int DEB_CYCLES = mrsc_pkg::DEB_CYC,
  parameter int DECEL_STEP = mrsc_pkg::DECEL_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic forward_run_in_i,
  input wire logic reverse_run_in_i,
  input wire logic data_select_lo_i,
  input wire logic data_select_hi_i,
  input wire logic alarm_reset_in_i,
  input wire logic brake_free_in_i,
  input wire logic input_polarity_switch_i,
  input wire logic [11:0] speed_cmd_wiper_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic motor_run_o,
  output logic motor_dir_rev_o,
  output logic motor_coast_o,
  output logic brake_release_o,
  output logic [10:0] motor_speed_o,
  output logic alarm_o,
  output logic test_error_o
);

  localparam int NIN = 6;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [10:0] clamp_speed(input logic [10:0] s, input logic hz60,
                                              input logic dec_off);
    logic [10:0] lo;
    logic [10:0] hi;
    lo = dec_off ? mrsc_pkg::SPD_MIN_NODEC : mrsc_pkg::SPD_MIN;
    hi = hz60 ? mrsc_pkg::SPD_MAX_60 : mrsc_pkg::SPD_MAX_50;
    clamp_speed = (s < lo) ? lo : ((s > hi) ? hi : s);
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronise, polarity and debounce
  // ----------------------------------------------------------------------
  logic [NIN-1:0] raw;
  logic [NIN-1:0] sync1_ff;
  logic [NIN-1:0] sync2_ff;
  logic pol1_ff;
  logic pol2_ff;
  logic [NIN-1:0] deb_ff;
  mrsc_pkg::mrsc_in_t in_s;

  assign raw = {forward_run_in_i, reverse_run_in_i, data_select_lo_i,
                data_select_hi_i, alarm_reset_in_i, brake_free_in_i};

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      pol1_ff <= 1'b0;
      pol2_ff <= 1'b0;
    end else begin
      sync1_ff <= raw;
      sync2_ff <= sync1_ff;
      pol1_ff <= input_polarity_switch_i;
      pol2_ff <= pol1_ff;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_deb
      logic [31:0] cnt_ff;
      logic lvl;
      // Source wiring inverts the optocoupler sense
      assign lvl = sync2_ff[gi] ^ pol2_ff;
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          cnt_ff <= '0;
          deb_ff[gi] <= 1'b0;
        end else if (lvl == deb_ff[gi]) begin
          cnt_ff <= '0;
        end else if (cnt_ff >= 32'(DEB_CYCLES - 1)) begin
          cnt_ff <= '0;
          deb_ff[gi] <= lvl;
        end else begin
          cnt_ff <= cnt_ff + 32'd1;
        end
      end
    end
  endgenerate

  assign in_s = mrsc_pkg::mrsc_in_t'(deb_ff);

  // ----------------------------------------------------------------------
  // Analog command synchronise (word held stable by converter)
  // ----------------------------------------------------------------------
  logic [11:0] adc1_ff;
  logic [11:0] adc2_ff;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      adc1_ff <= '0;
      adc2_ff <= '0;
    end else begin
      adc1_ff <= speed_cmd_wiper_i;
      adc2_ff <= adc1_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [5:0] ctrl_ff;
  logic [10:0] slot_ff [4];
  logic [10:0] panel_ff;
  logic [1:0] sel;
  logic wr_cmd;
  logic [10:0] cur_speed_ff;

  assign sel = {in_s.sel_hi, in_s.sel_lo};
  assign wr_cmd = reg_wr_i && (reg_addr_i == mrsc_pkg::ADDR_CMD);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_ff <= '0;
      panel_ff <= mrsc_pkg::SPD_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == mrsc_pkg::ADDR_CTRL) begin
        ctrl_ff <= reg_wdata_i[5:0];
      end
      if (reg_addr_i == mrsc_pkg::ADDR_PANEL) begin
        panel_ff <= reg_wdata_i[10:0];
      end
    end
  end

  generate
    for (gi = 0; gi < 4; gi++) begin : g_slot
      localparam logic [7:0] SLOT_ADDR = mrsc_pkg::ADDR_SPD0 + 8'(4 * gi);
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          slot_ff[gi] <= mrsc_pkg::SPD_RESET;
        end else if (wr_cmd && reg_wdata_i[mrsc_pkg::CMD_PANEL_WR] && sel == 2'(gi)) begin
          // Accepted in any motion state
          slot_ff[gi] <= clamp_speed(panel_ff, ctrl_ff[mrsc_pkg::CTRL_HZ60],
                                     ctrl_ff[mrsc_pkg::CTRL_DECEL_OFF]);
        end else if (reg_wr_i && reg_addr_i == SLOT_ADDR) begin
          slot_ff[gi] <= clamp_speed(reg_wdata_i[10:0], ctrl_ff[mrsc_pkg::CTRL_HZ60],
                                     ctrl_ff[mrsc_pkg::CTRL_DECEL_OFF]);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Target speed
  // ----------------------------------------------------------------------
  logic [10:0] span;
  logic [22:0] prod;
  logic [10:0] ext_spd;
  logic [10:0] target;
  logic [11:0] adc_eff;

  always_comb begin
    span = ctrl_ff[mrsc_pkg::CTRL_HZ60] ? mrsc_pkg::SPD_MAX_60 : mrsc_pkg::SPD_MAX_50;
    // 5 V range uses only the lower half of the converter span
    if (ctrl_ff[mrsc_pkg::CTRL_RANGE10]) begin
      adc_eff = adc2_ff;
    end else begin
      adc_eff = adc2_ff[11] ? 12'hfff : {adc2_ff[10:0], 1'b0};
    end
    prod = 23'(adc_eff) * 23'(span);
    ext_spd = clamp_speed(prod[22:12], ctrl_ff[mrsc_pkg::CTRL_HZ60],
                          ctrl_ff[mrsc_pkg::CTRL_DECEL_OFF]);
    if (ctrl_ff[mrsc_pkg::CTRL_EXT_EN] && sel == 2'b00) begin
      target = ext_spd;
    end else begin
      target = slot_ff[sel];
    end
    if (!ctrl_ff[mrsc_pkg::CTRL_HZ60] && target > mrsc_pkg::SPD_MAX_50) begin
      target = mrsc_pkg::SPD_RUN_50;
    end
  end

  // ----------------------------------------------------------------------
  // Power-on alarm
  // ----------------------------------------------------------------------
  logic boot_ff;
  logic [31:0] boot_cnt_ff;
  logic alarm_ff;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      boot_ff <= 1'b1;
      boot_cnt_ff <= '0;
      alarm_ff <= 1'b0;
    end else begin
      // Sample only once a level has crossed the synchroniser and a full debounce
      if (boot_ff) begin
        if (boot_cnt_ff >= 32'(DEB_CYCLES + SYNC_STAGES)) begin
          boot_ff <= 1'b0;
          if (in_s.forward_run_in || in_s.reverse_run_in) begin
            alarm_ff <= 1'b1;
          end
        end else begin
          boot_cnt_ff <= boot_cnt_ff + 32'd1;
        end
      end else if ((in_s.alm_rst || (wr_cmd && reg_wdata_i[mrsc_pkg::CMD_ALM_RESET]))
                   && !in_s.forward_run_in && !in_s.reverse_run_in) begin
        alarm_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Run state machine
  // ----------------------------------------------------------------------
  mrsc_pkg::mrsc_state_t state_ff;
  logic coast_ff;
  logic dir_ff;
  logic brake_rel_ff;
  logic test_err_ff;
  logic [31:0] ramp_cnt_ff;
  logic blocked;
  logic standstill;

  assign blocked = boot_ff || alarm_ff || in_s.free;
  assign standstill = (cur_speed_ff == 11'h000);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= mrsc_pkg::MRSC_IDLE;
      cur_speed_ff <= '0;
      coast_ff <= 1'b0;
      dir_ff <= 1'b0;
      test_err_ff <= 1'b0;
      ramp_cnt_ff <= '0;
    end else begin
      case (state_ff)
        mrsc_pkg::MRSC_IDLE: begin
          if (wr_cmd && reg_wdata_i[mrsc_pkg::CMD_TEST_START]) begin
            if (in_s.forward_run_in || in_s.reverse_run_in) begin
              test_err_ff <= 1'b1;
            end else if (!blocked) begin
              test_err_ff <= 1'b0;
              coast_ff <= 1'b0;
              dir_ff <= 1'b0;
              state_ff <= mrsc_pkg::MRSC_TEST;
            end
          end else if (!blocked && in_s.forward_run_in && !in_s.reverse_run_in) begin
            test_err_ff <= 1'b0;
            coast_ff <= 1'b0;
            dir_ff <= 1'b0;
            state_ff <= mrsc_pkg::MRSC_FWD;
          end else if (!blocked && in_s.reverse_run_in && !in_s.forward_run_in) begin
            test_err_ff <= 1'b0;
            coast_ff <= 1'b0;
            dir_ff <= 1'b1;
            state_ff <= mrsc_pkg::MRSC_REV;
          end
        end
        mrsc_pkg::MRSC_FWD, mrsc_pkg::MRSC_REV, mrsc_pkg::MRSC_TEST: begin
          if (wr_cmd && reg_wdata_i[mrsc_pkg::CMD_TEST_START] && (in_s.forward_run_in || in_s.reverse_run_in)) begin
            test_err_ff <= 1'b1;
          end
          if (state_ff == mrsc_pkg::MRSC_TEST) begin
            cur_speed_ff <= mrsc_pkg::SPD_TEST;
          end else begin
            cur_speed_ff <= target;
          end
          if (in_s.free || alarm_ff) begin
            coast_ff <= 1'b1;
            cur_speed_ff <= '0;
            state_ff <= mrsc_pkg::MRSC_IDLE;
          end else if (in_s.forward_run_in && in_s.reverse_run_in) begin
            cur_speed_ff <= '0;
            state_ff <= mrsc_pkg::MRSC_IDLE;
          end else if (state_ff == mrsc_pkg::MRSC_TEST) begin
            if (wr_cmd && reg_wdata_i[mrsc_pkg::CMD_TEST_STOP]) begin
              state_ff <= mrsc_pkg::MRSC_DECEL;
            end
          end else if ((state_ff == mrsc_pkg::MRSC_FWD && !in_s.forward_run_in) ||
                       (state_ff == mrsc_pkg::MRSC_REV && !in_s.reverse_run_in)) begin
            if (!in_s.forward_run_in && !in_s.reverse_run_in && ctrl_ff[mrsc_pkg::CTRL_COAST]) begin
              coast_ff <= 1'b1;
              cur_speed_ff <= '0;
              state_ff <= mrsc_pkg::MRSC_IDLE;
            end else begin
              state_ff <= mrsc_pkg::MRSC_DECEL;
            end
          end
          ramp_cnt_ff <= '0;
        end
        mrsc_pkg::MRSC_DECEL: begin
          if (in_s.free || standstill || (in_s.forward_run_in && in_s.reverse_run_in)) begin
            coast_ff <= in_s.free;
            cur_speed_ff <= '0;
            state_ff <= mrsc_pkg::MRSC_IDLE;
          end else if (ramp_cnt_ff >= 32'(DECEL_STEP - 1)) begin
            ramp_cnt_ff <= '0;
            cur_speed_ff <= cur_speed_ff - 11'd1;
          end else begin
            ramp_cnt_ff <= ramp_cnt_ff + 32'd1;
          end
        end
        default: begin
          state_ff <= mrsc_pkg::MRSC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Brake
  // ----------------------------------------------------------------------
  logic panel_rel_ff;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      panel_rel_ff <= 1'b0;
    end else if (wr_cmd && reg_wdata_i[mrsc_pkg::CMD_BRAKE_REL] &&
                 state_ff == mrsc_pkg::MRSC_IDLE && standstill) begin
      panel_rel_ff <= 1'b1;
    end else if ((wr_cmd && reg_wdata_i[mrsc_pkg::CMD_BRAKE_HOLD]) ||
                 state_ff != mrsc_pkg::MRSC_IDLE) begin
      panel_rel_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      brake_rel_ff <= 1'b0;
    end else begin
      brake_rel_ff <= in_s.free || panel_rel_ff || (state_ff != mrsc_pkg::MRSC_IDLE);
    end
  end

  // ----------------------------------------------------------------------
  // Outputs and read port
  // ----------------------------------------------------------------------
  assign motor_run_o = (state_ff != mrsc_pkg::MRSC_IDLE);
  assign motor_dir_rev_o = dir_ff;
  assign motor_coast_o = coast_ff;
  assign brake_release_o = brake_rel_ff;
  assign motor_speed_o = cur_speed_ff;
  assign alarm_o = alarm_ff;
  assign test_error_o = test_err_ff;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        mrsc_pkg::ADDR_CTRL: reg_rdata_o <= {26'h0, ctrl_ff};
        mrsc_pkg::ADDR_SPD0: reg_rdata_o <= {21'h0, slot_ff[0]};
        mrsc_pkg::ADDR_SPD1: reg_rdata_o <= {21'h0, slot_ff[1]};
        mrsc_pkg::ADDR_SPD2: reg_rdata_o <= {21'h0, slot_ff[2]};
        mrsc_pkg::ADDR_SPD3: reg_rdata_o <= {21'h0, slot_ff[3]};
        mrsc_pkg::ADDR_PANEL: reg_rdata_o <= {21'h0, panel_ff};
        mrsc_pkg::ADDR_STAT: reg_rdata_o <= {17'h0, in_s, boot_ff, brake_rel_ff,
                                              test_err_ff, alarm_ff, state_ff};
        mrsc_pkg::ADDR_SPEED: reg_rdata_o <= {21'h0, cur_speed_ff};
        default: reg_rdata_o <= 32'h0;
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

endmodule // mrsc_motor_run_speed_control

// ---- mrsc_run_properties.sv ----
`timescale 1ns/1ps
module mrsc_run_properties #(
  parameter int DEB_CYCLES = 4,
  parameter int DECEL_STEP = 2
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic forward_run_in_i,
  input wire logic reverse_run_in_i,
  input wire logic brake_free_in_i,
  input wire logic input_polarity_switch_i,
  input wire logic motor_run_o,
  input wire logic motor_dir_rev_o,
  input wire logic motor_coast_o,
  input wire logic brake_release_o,
  input wire logic [10:0] motor_speed_o,
  input wire logic alarm_o,
  input wire logic test_error_o
);
  // ----------------------------------------------------------------------
  // Pin levels as the controller means them
  // ----------------------------------------------------------------------
  localparam int SETTLE = DEB_CYCLES + 10;
  logic fwd_on;
  logic rev_on;
  logic free_on;
  logic [15:0] both_cnt_ff;
  logic [15:0] free_cnt_ff;
  assign fwd_on = forward_run_in_i ^ input_polarity_switch_i;
  assign rev_on = reverse_run_in_i ^ input_polarity_switch_i;
  assign free_on = brake_free_in_i ^ input_polarity_switch_i;

  // Saturate so a long hold never wraps back under the settle limit
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      both_cnt_ff <= 16'h0000;
    end else if (!(fwd_on && rev_on)) begin
      both_cnt_ff <= 16'h0000;
    end else if (both_cnt_ff != 16'hffff) begin
      both_cnt_ff <= both_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      free_cnt_ff <= 16'h0000;
    end else if (!free_on) begin
      free_cnt_ff <= 16'h0000;
    end else if (free_cnt_ff != 16'hffff) begin
      free_cnt_ff <= free_cnt_ff + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_alarm_no_run: assert property (alarm_o |-> !motor_run_o)
    else $error("motor runs while alarm raised");
  a_fwd_dir_start: assert property ($rose(motor_run_o) && fwd_on && !rev_on
    |-> ##[0:1] !motor_dir_rev_o) else $error("forward start not forward");
  a_rev_dir_start: assert property ($rose(motor_run_o) && rev_on && !fwd_on
    |-> ##[0:1] motor_dir_rev_o) else $error("reverse start not reverse");
  a_both_on_stop: assert property (both_cnt_ff > SETTLE
    |-> !motor_run_o && motor_speed_o == 11'h000) else $error("both on did not stop");
  a_free_coasts: assert property (free_cnt_ff > SETTLE
    |-> !motor_run_o && brake_release_o) else $error("free input did not coast");
  a_coast_idle: assert property (motor_coast_o |-> !motor_run_o)
    else $error("coast flag while running");
  a_speed_cap: assert property (motor_speed_o <= 11'h640)
    else $error("speed above top limit");
  a_alarm_clear_off: assert property ($fell(alarm_o) |-> !fwd_on && !rev_on)
    else $error("alarm cleared with run input on");
  a_test_err_cause: assert property ($rose(test_error_o) |-> fwd_on || rev_on)
    else $error("test error without run input");
endmodule // mrsc_run_properties

bind mrsc_motor_run_speed_control mrsc_run_properties #(
  .DEB_CYCLES(DEB_CYCLES),
  .DECEL_STEP(DECEL_STEP)
) mrsc_run_properties_i (
  .clk_i, .resetn_i, .forward_run_in_i, .reverse_run_in_i, .brake_free_in_i,
  .input_polarity_switch_i, .motor_run_o, .motor_dir_rev_o, .motor_coast_o,
  .brake_release_o, .motor_speed_o, .alarm_o, .test_error_o
);

// ---- mrsc_ctrl_model.sv ----
`timescale 1ns/1ps
module mrsc_ctrl_model #(
  parameter int HOLD_CYCLES = 8
) (
  input wire logic clk_i,
  input wire logic polarity_i,
  input wire mrsc_pkg::mrsc_in_t want_i,
  output logic fwd_pin_o,
  output logic rev_pin_o,
  output logic sel_lo_pin_o,
  output logic sel_hi_pin_o,
  output logic alm_pin_o,
  output logic free_pin_o
);
  // ----------------------------------------------------------------------
  // Controller outputs, all off at power-up unless asked otherwise
  // ----------------------------------------------------------------------
  mrsc_pkg::mrsc_in_t held_ff = '0;
  logic [15:0] hold_cnt_ff = 16'h0000;

  // A new level is taken only once the last one has stood its minimum time
  always @(posedge clk_i) begin
    if (hold_cnt_ff != 16'h0000) begin
      hold_cnt_ff <= hold_cnt_ff - 16'h0001;
    end else if (want_i != held_ff) begin
      held_ff <= want_i;
      hold_cnt_ff <= 16'(HOLD_CYCLES);
    end
  end

  // Sink drives high for on, source drives low for on
  assign fwd_pin_o = held_ff.forward_run_in ^ polarity_i;
  assign rev_pin_o = held_ff.reverse_run_in ^ polarity_i;
  assign sel_lo_pin_o = held_ff.sel_lo ^ polarity_i;
  assign sel_hi_pin_o = held_ff.sel_hi ^ polarity_i;
  assign alm_pin_o = held_ff.alm_rst ^ polarity_i;
  assign free_pin_o = held_ff.free ^ polarity_i;
endmodule // mrsc_ctrl_model

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  localparam int DEB = 4;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic input_polarity_switch_i = 1'b0;
  logic [11:0] speed_cmd_wiper_i = 12'h000;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic forward_run_in_i, reverse_run_in_i, data_select_lo_i, data_select_hi_i;
  logic alarm_reset_in_i, brake_free_in_i, motor_run_o, motor_dir_rev_o, motor_coast_o;
  logic brake_release_o, alarm_o, test_error_o;
  logic [31:0] reg_rdata_o;
  logic [10:0] motor_speed_o;
  logic [31:0] rv;
  mrsc_pkg::mrsc_in_t want = 6'h20;
  int fail_count = 0;
  int compares = 0;

  mrsc_ctrl_model #(.HOLD_CYCLES(DEB + 4)) mrsc_ctrl_model_i (
    .clk_i(clk_i), .polarity_i(input_polarity_switch_i), .want_i(want),
    .fwd_pin_o(forward_run_in_i), .rev_pin_o(reverse_run_in_i),
    .sel_lo_pin_o(data_select_lo_i), .sel_hi_pin_o(data_select_hi_i),
    .alm_pin_o(alarm_reset_in_i), .free_pin_o(brake_free_in_i)
  );
  mrsc_motor_run_speed_control #(.DEB_CYCLES(DEB), .DECEL_STEP(2))
    mrsc_motor_run_speed_control_i (
    .clk_i, .resetn_i, .forward_run_in_i, .reverse_run_in_i, .data_select_lo_i,
    .data_select_hi_i, .alarm_reset_in_i, .brake_free_in_i, .input_polarity_switch_i,
    .speed_cmd_wiper_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .motor_run_o, .motor_dir_rev_o, .motor_coast_o, .brake_release_o, .motor_speed_o,
    .alarm_o, .test_error_o
  );

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 rv = reg_rdata_o;
  endtask

  task automatic cmd(input logic [31:0] d);
    wr_reg(mrsc_pkg::ADDR_CMD, d);
  endtask

  // Pin order: fwd, rev, sel_lo, sel_hi, alarm reset, free
  task automatic pins(input logic [5:0] p);
    @(posedge clk_i);
    want <= p;
  endtask

  task automatic wait_run(input logic v);
    int n;
    n = 0;
    while (motor_run_o !== v && n < 2000) begin
      cyc(1);
      n++;
    end
    #1 chk("run", 32'(v), 32'(motor_run_o));
  endtask

  task automatic stop_now(input logic [5:0] sel);
    pins(6'h30 | sel);
    wait_run(1'b0);
    chk("stop speed", 32'h0, 32'(motor_speed_o));
    pins(sel);
    cyc(30);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_boot();
    cyc(40);
    chk("alarm", 32'h1, 32'(alarm_o));
    chk("run", 32'h0, 32'(motor_run_o));
    rd_reg(mrsc_pkg::ADDR_STAT);
    chk("status", 32'h4021, rv);
    rd_reg(mrsc_pkg::ADDR_SPD0);
    chk("slot0", 32'h12c, rv);
    rd_reg(8'h40);
    chk("unmapped", 32'h0, rv);
    cmd(32'h20);
    cyc(10);
    chk("alarm held", 32'h1, 32'(alarm_o));
    pins(6'h00);
    cyc(30);
    pins(6'h02);
    cyc(30);
    chk("alarm clear", 32'h0, 32'(alarm_o));
    pins(6'h00);
  endtask

  task automatic t_run();
    wr_reg(mrsc_pkg::ADDR_SPD1, 32'h320);
    pins(6'h28);
    wait_run(1'b1);
    cyc(5);
    chk("speed", 32'h320, 32'(motor_speed_o));
    chk("dir", 32'h0, 32'(motor_dir_rev_o));
    pins(6'h08);
    cyc(30);
    chk("decel run", 32'h1, 32'(motor_run_o));
    chk("decel speed", 32'h1, 32'(motor_speed_o < 11'h320));
    stop_now(6'h08);
    pins(6'h18);
    wait_run(1'b1);
    cyc(5);
    chk("dir", 32'h1, 32'(motor_dir_rev_o));
    stop_now(6'h08);
    wr_reg(mrsc_pkg::ADDR_CTRL, 32'h4);
    pins(6'h28);
    wait_run(1'b1);
    pins(6'h08);
    cyc(30);
    chk("coast run", 32'h0, 32'(motor_run_o));
    chk("coast", 32'h1, 32'(motor_coast_o));
    wr_reg(mrsc_pkg::ADDR_CTRL, 32'h0);
  endtask

  task automatic t_free_test();
    pins(6'h28);
    wait_run(1'b1);
    pins(6'h29);
    cyc(30);
    chk("free run", 32'h0, 32'(motor_run_o));
    chk("free brake", 32'h1, 32'(brake_release_o));
    pins(6'h01);
    cyc(30);
    cmd(32'h2);
    cyc(10);
    chk("test free", 32'h0, 32'(motor_run_o));
    pins(6'h00);
    cyc(30);
    wr_reg(mrsc_pkg::ADDR_SPD0, 32'h3e8);
    cmd(32'h2);
    wait_run(1'b1);
    cyc(3);
    chk("test speed", 32'h12c, 32'(motor_speed_o));
    cmd(32'h4);
    wait_run(1'b0);
    pins(6'h20);
    wait_run(1'b1);
    cyc(3);
    chk("slot0 speed", 32'h3e8, 32'(motor_speed_o));
    cmd(32'h2);
    cyc(5);
    chk("test error", 32'h1, 32'(test_error_o));
    cmd(32'h8);
    stop_now(6'h00);
    chk("brake run", 32'h0, 32'(brake_release_o));
    cmd(32'h8);
    cyc(5);
    chk("brake stop", 32'h1, 32'(brake_release_o));
    cmd(32'h10);
    cyc(5);
    chk("brake hold", 32'h0, 32'(brake_release_o));
  endtask

  task automatic t_speed();
    logic [31:0] tc[4] = '{32'h0, 32'h8, 32'h0, 32'h10};
    logic [31:0] tv[4] = '{32'h32, 32'h32, 32'h7d0, 32'h7d0};
    logic [31:0] te[4] = '{32'h12c, 32'h5a, 32'h578, 32'h640};
    for (int i = 0; i < 4; i++) begin
      wr_reg(mrsc_pkg::ADDR_CTRL, tc[i]);
      wr_reg(mrsc_pkg::ADDR_SPD3, tv[i]);
      rd_reg(mrsc_pkg::ADDR_SPD3);
      chk("clamp", te[i], rv);
    end
    wr_reg(mrsc_pkg::ADDR_CTRL, 32'h0);
    pins(6'h04);
    cyc(30);
    wr_reg(mrsc_pkg::ADDR_PANEL, 32'h7d0);
    cmd(32'h1);
    rd_reg(mrsc_pkg::ADDR_SPD2);
    chk("slot2", 32'h578, rv);
    rd_reg(mrsc_pkg::ADDR_SPD1);
    chk("slot1", 32'h320, rv);
    pins(6'h2c);
    wait_run(1'b1);
    cyc(3);
    chk("50 Hz run", 32'h58c, 32'(motor_speed_o));
    wr_reg(mrsc_pkg::ADDR_PANEL, 32'h3e8);
    cmd(32'h1);
    cyc(5);
    chk("panel run", 32'h3e8, 32'(motor_speed_o));
    rd_reg(mrsc_pkg::ADDR_SPEED);
    chk("speed reg", 32'h3e8, rv);
    stop_now(6'h0c);
  endtask

  task automatic t_analog();
    wr_reg(mrsc_pkg::ADDR_CTRL, 32'h3);
    speed_cmd_wiper_i <= 12'h400;
    pins(6'h20);
    wait_run(1'b1);
    cyc(10);
    chk("10 V", 32'h15e, 32'(motor_speed_o));
    wr_reg(mrsc_pkg::ADDR_CTRL, 32'h1);
    cyc(10);
    chk("5 V", 32'h2bc, 32'(motor_speed_o));
    @(posedge clk_i) speed_cmd_wiper_i <= 12'h600;
    cyc(10);
    chk("wiper up", 32'h41a, 32'(motor_speed_o));
    pins(6'h28);
    cyc(30);
    chk("select on", 32'h320, 32'(motor_speed_o));
    stop_now(6'h08);
    wr_reg(mrsc_pkg::ADDR_CTRL, 32'h0);
    @(posedge clk_i) input_polarity_switch_i <= 1'b1;
    cyc(30);
    pins(6'h20);
    wait_run(1'b1);
    stop_now(6'h00);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    cyc(20000);
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_boot();
    t_run();
    t_free_test();
    t_speed();
    t_analog();
    print_verdict();
  end
endmodule // testbench
